// [rtl/sadc_dev.sv]
`timescale 1ns/100ps
// Contract
// R01: select fall starts conversion, rise ends frame
// R02: conversion advances only on host clock edges
// R03: first zero at select fall, then per edge
// R04: falling-edge host captures last bit edge 16
// R05: rising-edge host misses first zero
// R06: select low with clock low: rising capture
// R07: select fall puts sample-hold into hold
// R08: conversion ends on edge 13, result lsb
// R09: edge 14 returns sample-hold to sample
// R10: host may end after edge 14 or 16
// R11: fast rate uses 48MHz clock, 333ns period
// R12: output undriven while select high
// R13: frame: two zeros, 12 bits msb first, two zeros
// R14: output released at edge 16 or select rise
// R15: power-up with select high enters sleep
// R16: rise between edges 2 and 10 sleeps
// R17: rise after edge 10 stays powered
// R18: wake with one dummy frame, result discarded
// R19: host allows one frame wake-up time
// R20: sleep holds; wake frame samples after edge 1
// R21: output bits change only on falling edges
// R22: straight binary result, saturating
// R23: count falling edges from each select fall
module sadc_dev #(
   parameter int RES_W = sadc_pkg::RES_W
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // link
   sadc_if.dev                   lnk,
   // analog side, already quantised straight binary
   input  wire logic [RES_W-1:0] conv_code,
   // status
   output logic                  powered,
   output logic                  tracking,
   output logic                  busy
);
   localparam logic [4:0] N16 = 5'(sadc_pkg::FRAME_EDGES);
   localparam logic [4:0] N13 = 5'(sadc_pkg::CONV_DONE_FE);
   localparam logic [4:0] N14 = 5'(sadc_pkg::SAMPLE_FE);
   localparam logic [4:0] N02 = 5'(sadc_pkg::SLEEP_LO_FE);
   localparam logic [4:0] N10 = 5'(sadc_pkg::SLEEP_HI_FE);
   localparam logic [4:0] N01 = 5'(sadc_pkg::WAKE_SAMP_FE);

   sadc_pkg::sadc_mode_t mode_r;
   sadc_pkg::sadc_mode_t mode_nxt;
   logic [1:0]       cs_sy_r;
   logic [1:0]       sck_sy_r;
   logic             cs_d_r;
   logic             sck_d_r;
   logic [4:0]       cnt_r;
   logic [RES_W-1:0] held_r;
   logic             sdo_r;
   logic             oe_r;
   logic             hold_r;
   logic             waking_r;

   // two-stage synchronisers; only stage two feeds the edge logic
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         cs_sy_r  <= 2'h3;
         sck_sy_r <= 2'h0;
         cs_d_r   <= 1'h1;
         sck_d_r  <= 1'h0;
      end
      else
      begin
         cs_sy_r  <= {cs_sy_r[0], lnk.frame_n};
         sck_sy_r <= {sck_sy_r[0], lnk.sck};
         cs_d_r   <= cs_sy_r[1];
         sck_d_r  <= sck_sy_r[1];
      end
   end

   // the wake, sample and last-fall actions go through one decode, so they
   // agree on which falling edge a number means
   function automatic logic fall_at(input logic       fall,
                                    input logic [4:0] cnt,
                                    input logic [4:0] n);
      fall_at = fall && (cnt == n);
   endfunction

   // a select edge and a clock edge seen in one cycle: the select wins and
   // the clock edge is lost, so a host must keep the two apart
   wire cs_fall  = cs_d_r && !cs_sy_r[1];   // R01
   wire cs_rise  = !cs_d_r && cs_sy_r[1];
   wire in_frame = !cs_sy_r[1];
   // falling shift edges only count inside a frame
   wire sck_fall = sck_d_r && !sck_sy_r[1] && in_frame && !cs_fall; // R02
   wire [4:0] cnt_inc = cnt_r + 5'h01;
   // bit for frame position p: 0,1 zeros, 2..13 msb..lsb, rest zero
   wire [4:0] bidx = 5'(RES_W + 1) - cnt_inc;
   wire       data_slot = (cnt_inc >= N02) && (cnt_inc <= N13);
   wire       next_bit = data_slot ? held_r[bidx[3:0]] : 1'b0; // R13
   wire early_sleep = cs_rise && (cnt_r >= N02) && (cnt_r < N10); // R16

   // count-triggered actions
   wire wake_fall = fall_at(sck_fall, cnt_inc, N01) && waking_r; // R20
   wire samp_fall = fall_at(sck_fall, cnt_inc, N14);             // R09
   wire last_fall = fall_at(sck_fall, cnt_inc, N16);             // R14
   wire wake_drop = cs_rise && waking_r && (cnt_r < N16);        // R18

   // mode decode: sleep, powered idle, converting
   always_comb
   begin
      mode_nxt = mode_r;
      unique case (mode_r)
         sadc_pkg::SADC_SLEEP:
            if (cs_fall)
               mode_nxt = sadc_pkg::SADC_CONV;
         sadc_pkg::SADC_IDLE:
            if (cs_fall)
               mode_nxt = sadc_pkg::SADC_CONV;
         sadc_pkg::SADC_CONV:
            if (early_sleep)
               mode_nxt = sadc_pkg::SADC_SLEEP;  // R16
            else if (wake_drop)
               mode_nxt = sadc_pkg::SADC_SLEEP;  // wake aborted
            else if (cs_rise || last_fall)
               mode_nxt = sadc_pkg::SADC_IDLE;   // R17 R18
      endcase
   end

   // mode, wake tracking and edge counter
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mode_r   <= sadc_pkg::SADC_SLEEP;       // R15
         waking_r <= 1'b0;
         cnt_r    <= '0;
      end
      else
      begin
         mode_r <= mode_nxt;
         if (cs_fall)
            waking_r <= (mode_r == sadc_pkg::SADC_SLEEP); // R18
         else if (mode_nxt == sadc_pkg::SADC_IDLE)
            waking_r <= 1'b0;
         // the count stops at sixteen, so extra clocks cannot wrap it into
         // the sleep window of the next select rise
         if (cs_fall || cs_rise)
            cnt_r <= '0;                          // R23
         else if (sck_fall && cnt_r != N16)
            cnt_r <= cnt_inc;
      end
   end

   // sample-and-hold and captured code; a waking frame's code is loaded as zero
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         hold_r <= 1'b1;                         // R20
         held_r <= '0;
      end
      else if (cs_fall)
      begin
         hold_r <= 1'b1;                         // R07
         held_r <= (mode_r == sadc_pkg::SADC_SLEEP) ? '0 : conv_code; // R22
      end
      // a waking frame starts sampling at its first fall, not its fourteenth
      else if (wake_fall)
         hold_r <= 1'b0;                         // R20
      else if (samp_fall)
         hold_r <= 1'b0;                         // R09
      else if (mode_nxt == sadc_pkg::SADC_SLEEP)
         hold_r <= 1'b1;
      else if (cs_rise)
         hold_r <= 1'b0;
   end

   // serial output: updated at select edges and falling shift edges only
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sdo_r <= 1'b0;
         oe_r  <= 1'b0;                          // R12
      end
      else if (cs_fall)
      begin
         sdo_r <= 1'b0;                          // R03
         oe_r  <= 1'b1;                          // R12
      end
      else if (cs_rise)
         oe_r <= 1'b0;                           // R14
      else if (sck_fall && oe_r)
      begin
         sdo_r <= next_bit;                      // R21 R08
         // the line goes quiet at the sixteenth fall even if select stays low
         if (last_fall)
            oe_r <= 1'b0;                        // R14
      end
   end

   // link pins and status
   assign lnk.sdo_o  = sdo_r;
   assign lnk.sdo_oe = oe_r;
   // a waking device is not yet powered; it counts as awake only once
   // the dummy frame has run its sixteenth fall
   assign powered    = (mode_r != sadc_pkg::SADC_SLEEP) && !waking_r; // R18
   assign tracking   = !hold_r;
   assign busy       = (mode_r == sadc_pkg::SADC_CONV);
endmodule

// [rtl/sadc_fifo.sv]
`timescale 1ns/100ps
module sadc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // honest flags from the occupancy count
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];

   // storage and pointers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wp_r] <= in_data;
            wp_r        <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop)
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [rtl/sadc_host.sv]
`timescale 1ns/100ps
// host end: runs frames, shifts data in on falling edges, queues results
module sadc_host #(
   parameter int RES_W = sadc_pkg::RES_W,
   parameter int DEPTH = sadc_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // link
   sadc_if.host                  lnk,
   // user control
   input  wire logic             start,
   input  wire logic             short_frame,
   input  wire logic             sleep_req,
   // result stream
   output logic                  res_valid,
   input  wire logic             res_ready,
   output logic      [RES_W-1:0] res_data,
   output logic                  awake
);
   localparam logic [4:0] N16 = 5'(sadc_pkg::FRAME_EDGES);
   localparam logic [4:0] N14 = 5'(sadc_pkg::SAMPLE_FE);
   localparam logic [4:0] N04 = 5'(sadc_pkg::SLEEP_LO_FE + 2);
   localparam logic [2:0] HALF = 3'(sadc_pkg::SCK_HALF - 1); // R11
   localparam logic [2:0] GAP  = 3'(sadc_pkg::SEL_GAP - 1);
   typedef enum logic [1:0] {SADCH_IDLE, SADCH_RUN, SADCH_GAP} sadch_st_t;

   sadch_st_t  st_r;
   logic [2:0] div_r;
   logic       sck_r;
   logic       cs_r;
   logic [4:0] fe_r;
   logic [4:0] stop_r;
   logic       dummy_r;
   logic       awake_r;
   logic [1:0] sdo_sy_r;
   logic [15:0] sh_r;
   logic       push_r;
   logic [RES_W-1:0] word_r;
   logic       f_ready;

   // data line synchronised before use
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         sdo_sy_r <= 2'h0;
      else
         sdo_sy_r <= {sdo_sy_r[0], lnk.sdo};
   end

   wire tick = (div_r == HALF);
   // clock falls when high at a tick; capture edge n takes bit n-1 (R04)
   wire fall = (st_r == SADCH_RUN) && tick && sck_r;
   wire can_go = start && f_ready && !push_r;  // back-pressure stalls

   // frame sequencer with divided shift clock
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r    <= SADCH_IDLE;
         div_r   <= '0;
         sck_r   <= 1'b0;
         cs_r    <= 1'b1;
         fe_r    <= '0;
         stop_r  <= N16;
         dummy_r <= 1'b0;
         awake_r <= 1'b0;
         sh_r    <= '0;
         push_r  <= 1'b0;
         word_r  <= '0;
      end
      else
      begin
         push_r <= 1'b0;
         div_r  <= tick ? '0 : div_r + 3'h1;
         unique case (st_r)
            SADCH_IDLE:
               if (can_go || (sleep_req && awake_r))
               begin
                  st_r    <= SADCH_RUN;
                  cs_r    <= 1'b0;              // R01
                  div_r   <= '0;
                  fe_r    <= '0;
                  dummy_r <= !awake_r;          // R18
                  stop_r  <= (sleep_req && awake_r) ? N04
                           : (short_frame && awake_r) ? N14 : N16; // R10
               end
            SADCH_RUN:
               if (tick)
               begin
                  sck_r <= !sck_r;              // R02
                  if (fall)
                  begin
                     fe_r <= fe_r + 5'h01;
                     sh_r <= {sh_r[14:0], sdo_sy_r[1]};
                     if (fe_r + 5'h01 == stop_r)
                     begin
                        st_r  <= SADCH_GAP;
                        sck_r <= 1'b0;
                        div_r <= '0;
                     end
                  end
               end
            SADCH_GAP:
               // select rises half a clock after the last fall: a device that
               // synchronises both pins would lose a fall seen with the rise
               if (div_r == GAP && !cs_r)
                  cs_r <= 1'b1;                 // R10
               else if (div_r == GAP)
               begin
                  st_r <= SADCH_IDLE;
                  if (stop_r == N04)
                     awake_r <= 1'b0;           // R16
                  else if (!dummy_r)
                  begin
                     push_r <= 1'b1;
                     word_r <= (stop_r == N16) ? sh_r[13:2] : sh_r[11:0];
                  end
                  else
                     awake_r <= 1'b1;           // R19
               end
            default:
               st_r <= SADCH_IDLE;
         endcase
      end
   end

   assign lnk.sck     = sck_r;
   assign lnk.frame_n = cs_r;
   assign awake       = awake_r;

   sadc_fifo #(
      .WIDTH (RES_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (push_r),
      .in_ready  (f_ready),
      .in_data   (word_r),
      .out_valid (res_valid),
      .out_ready (res_ready),
      .out_data  (res_data)
   );
endmodule

// [rtl/sadc_if.sv]
`timescale 1ns/100ps
// three-wire link; a released data line reads low, as through a pull-down
interface sadc_if;
   logic frame_n;
   logic sck;
   logic sdo_o;
   logic sdo_oe;
   wire  sdo = sdo_oe && sdo_o;
   modport dev  (input frame_n, input sck, output sdo_o, output sdo_oe);
   modport host (output frame_n, output sck, input sdo);
endinterface

// [rtl/sadc_pkg.sv]
package sadc_pkg;
   // frame layout, counted in shift clock falling edges
   localparam int RES_W        = 12;
   localparam int FRAME_EDGES  = 16;
   localparam int CONV_DONE_FE = 13;
   localparam int SAMPLE_FE    = 14;
   localparam int SLEEP_LO_FE  = 2;
   localparam int SLEEP_HI_FE  = 10;
   localparam int WAKE_SAMP_FE = 1;
   localparam int CNT_W        = 5;
   // host shift clock: half period in system clocks
   localparam int SCK_HALF     = 4;
   localparam int SEL_GAP      = 4;
   localparam int FIFO_DEPTH   = 16;
   typedef enum logic [1:0] {SADC_SLEEP, SADC_IDLE, SADC_CONV} sadc_mode_t;
endpackage

// [tb/sadc_props.sv]
`timescale 1ns/100ps
module sadc_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // link wires
   input wire logic frame_n,
   input wire logic sck,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   logic       sck_r;
   logic [4:0] fe_cnt_r;
   logic [4:0] fe_cnt_nxt;
   logic [3:0] since_r;
   logic [3:0] since_nxt;
   wire        sck_fall = sck_r && !sck;
   // falls since select fall; held at zero while select is high
   assign fe_cnt_nxt = frame_n ? 5'h00 : fe_cnt_r + {4'h0, sck_fall};
   // saturating, so a long idle never wraps back into range
   assign since_nxt = sck_fall ? 4'h0 : since_r + {3'h0, since_r != 4'hF};
   always_ff @(posedge sys_clk)
   begin
      sck_r    <= rst ? 1'b0 : sck;
      fe_cnt_r <= rst ? 5'h00 : fe_cnt_nxt;
      since_r  <= rst ? 4'hF : since_nxt;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_release_on_rise:
      assert property ($rose(frame_n) |-> ##[1:6] !sdo_oe)
      else $error("data line still driven after select rise");
   a_idle_quiet:
      assert property (frame_n [*8] |-> !sdo_oe && !sck)
      else $error("link active while select high");
   a_drive_on_fall:
      assert property ($fell(frame_n) |-> ##[1:6] sdo_oe)
      else $error("data line not driven after select fall");
   a_first_zero:
      assert property ($rose(sdo_oe) |-> !sdo_o)
      else $error("first frame bit not zero");
   a_bits_on_fall:
      assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o)
                       |-> since_r <= 4'h6)
      else $error("data bit changed away from a clock fall");
   a_pad_zeros:
      assert property ($changed(fe_cnt_r)
                       && fe_cnt_r inside {5'h01, 5'h0E, 5'h0F}
                       |-> ##5 (!sdo_o || !sdo_oe))
      else $error("padding bit not zero");
   a_frame_close:
      assert property ($rose(frame_n) |-> fe_cnt_r inside {5'h04, 5'h0E, 5'h10})
      else $error("frame closed after an unexpected fall count");
   a_clock_in_frame:
      assert property ($changed(sck) |-> !frame_n)
      else $error("shift clock moved outside a frame");
   a_fall_limit:
      assert property (fe_cnt_r <= 5'h10)
      else $error("more than sixteen falls in a frame");
endmodule

// [tb/serial_adc_conversion_interface_test.sv]
`timescale 1ns/100ps
module serial_adc_conversion_interface_test;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        start = 1'b0;
   logic        short_frame = 1'b0;
   logic        sleep_req = 1'b0;
   logic        res_ready = 1'b0;
   logic        rdy_en = 1'b0;
   logic [11:0] conv_code = 12'h000;
   logic [11:0] res_data;
   logic        res_valid, awake, powered, tracking, busy, powered_b;
   logic        pw_m, pw_st, fn_d, sk_d, ok;
   logic [15:0] word;
   logic [3:0]  mode;
   logic [11:0] exp_q[$];
   logic [5:0]  raw_pw = 6'h33;
   int          raw_len[6] = '{16, 12, 3, 8, 16, 11};
   int          seed = 7;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          n_fe, n_code, cyc, n_ok, i, ph;
   sadc_if lnk ();
   sadc_if lnk_b ();
   always #2 sys_clk = ~sys_clk;
   sadc_dev u_sadc_dev (.sys_clk(sys_clk), .rst(rst), .lnk(lnk.dev),
      .conv_code(conv_code), .powered(powered), .tracking(tracking),
      .busy(busy));
   // second device, driven by hand to break the host's habits
   sadc_dev u_sadc_dev_b (.sys_clk(sys_clk), .rst(rst), .lnk(lnk_b.dev),
      .conv_code(conv_code), .powered(powered_b), .tracking(), .busy());
   sadc_host u_sadc_host (.sys_clk(sys_clk), .rst(rst), .lnk(lnk.host),
      .start(start), .short_frame(short_frame), .sleep_req(sleep_req),
      .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
      .awake(awake));
   sadc_props u_sadc_props (.sys_clk(sys_clk), .rst(rst),
      .frame_n(lnk.frame_n), .sck(lnk.sck), .sdo_o(lnk.sdo_o),
      .sdo_oe(lnk.sdo_oe));
   function automatic logic [15:0] frame_word(input logic pw,
                                              input logic [11:0] code);
      frame_word = {2'b00, pw ? code : 12'h000, 2'b00};
   endfunction
   // hold until fall 14; a waking device samples from fall 1 on
   function automatic logic track_exp(input logic pw, input int n);
      track_exp = (n >= 15) || (n >= 2 && !pw);
   endfunction
   // full-scale, zero and mid-scale codes first, then random ones
   function automatic logic [11:0] next_code(input int idx);
      logic [31:0] r;
      r = $random(seed);
      case (idx)
         0: next_code = 12'hFFF;
         1: next_code = 12'h000;
         2: next_code = 12'h800;
         default: next_code = r[11:0];
      endcase
   endfunction
   task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // start is held until the host opens the frame, bounded
   task automatic run_frame(input logic shrt, input logic slp,
                            output logic got);
      int k;
      start <= 1'b1;
      short_frame <= shrt;
      sleep_req <= slp;
      got = 1'b0;
      for (k = 0; k < 400 && !got; k++)
      begin
         @(posedge sys_clk);
         got = !lnk.frame_n;
      end
      start <= 1'b0;
      for (k = 0; k < 400 && got && !lnk.frame_n; k++)
         @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic wait_drain;
      int k;
      for (k = 0; k < 3000 && exp_q.size() != 0; k++)
         @(posedge sys_clk);
      cmp(16'(exp_q.size()), 16'h0000);
   endtask
   // half periods of 15 or 16 cycles average 62.5 ns: a 125 ns link clock
   task automatic link_half;
      ph = ph + 5;
      repeat (ph >= 8 ? 16 : 15) @(posedge sys_clk);
      if (ph >= 8)
         ph = ph - 8;
   endtask
   // link clock unrelated to the device's sampling, driven on clock edges
   task automatic raw_frame(input int n);
      lnk_b.frame_n <= 1'b0;
      link_half;
      repeat (n)
      begin
         lnk_b.sck <= 1'b1;
         link_half;
         lnk_b.sck <= 1'b0;
         link_half;
      end
      lnk_b.frame_n <= 1'b1;
      repeat (25) @(posedge sys_clk);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      res_ready <= rdy_en && ($random(seed) % 3 != 0);
      if (cyc == 30000)
      begin
         error_cnt++;
         finish_test;
      end
   end
   // results must leave in frame order
   always @(posedge sys_clk)
      if (!rst && res_valid && res_ready)
         cmp(16'(res_data), 16'(exp_q.pop_front()));
   // link monitor rebuilds each frame and the power state
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         pw_m = 1'b0;
         fn_d = 1'b1;
         sk_d = 1'b0;
      end
      else
      begin
         if (fn_d && !lnk.frame_n)
         begin
            pw_st = pw_m;
            word = frame_word(pw_m, conv_code);
            n_fe = 0;
            cmp(16'(awake), 16'(pw_m));
         end
         // a rising-edge host that dropped select with the clock low
         if (!lnk.frame_n && !sk_d && lnk.sck && n_fe < 16)
            cmp(16'(lnk.sdo), 16'(word[15 - n_fe]));
         if (!lnk.frame_n && sk_d && !lnk.sck && n_fe < 16)
         begin
            n_fe++;
            cmp(16'(lnk.sdo), 16'(word[16 - n_fe]));
            cmp(16'(tracking), 16'(track_exp(pw_st, n_fe)));
            cmp(16'(busy), 16'h0001);
            if (n_fe == 2)
               cmp(16'(powered), 16'(pw_st));
         end
         if (!fn_d && lnk.frame_n)
         begin
            if (pw_st && n_fe >= 14)
               exp_q.push_back(word[13:2]);
            if (!pw_st)
               pw_m = (n_fe >= 16);
            else if (n_fe >= 2 && n_fe <= 10)
               pw_m = 1'b0;
            conv_code <= next_code(n_code++);
         end
         fn_d = lnk.frame_n;
         sk_d = lnk.sck;
      end
   end
   initial
   begin
      lnk_b.frame_n = 1'b1;
      lnk_b.sck = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      cmp(16'(powered), 16'h0000);
      cmp(16'(awake), 16'h0000);
      rdy_en <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
         mode = 4'($random(seed));
         run_frame(mode[0], mode[3:1] == 3'h0, ok);
      end
      // fill the result buffer until the host refuses to start
      run_frame(1'b0, 1'b0, ok);
      wait_drain;
      rdy_en <= 1'b0;
      n_ok = 0;
      ok = 1'b1;
      while (ok && n_ok < 20)
      begin
         run_frame(1'b0, 1'b0, ok);
         n_ok += int'(ok);
      end
      cmp(16'(n_ok), 16'(sadc_pkg::FIFO_DEPTH));
      rdy_en <= 1'b1;
      wait_drain;
      for (i = 0; i < 6; i++)
      begin
         raw_frame(raw_len[i]);
         cmp(16'(powered_b), 16'(raw_pw[i]));
         cmp(16'(lnk_b.sdo_oe), 16'h0000);
      end
      finish_test;
   end
endmodule
